// >>> rtl/shunt_power_measurement_engine.sv
// Function
// - Each channel's conversion period is selectable from 140 us to 8.244 ms.
// - Period and averaging fields of configuration are independent fields.
// - Shunt and bus conversion periods are set separately.
// - Power step is fixed at 25 times the current step.
// - After calibration write, current and power refresh from each measurement.
// - Current and power stay zero until calibration is written.
// - Current equals signed shunt result times calibration divided by 2048.
// - Power equals current magnitude times bus result divided by 20000.
// - All four values are averaged and published after the last sample.
// - Done flag rises only after conversions, averaging and scaling finish.
`timescale 1ns/1ps
module shunt_power_measurement_engine
  import meas_pkg::*;
#(
  parameter int CYCLES_PER_US = CYC_PER_US
) (
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic        link_clock_in,
  input  wire logic [15:0] shunt_sample_in,
  input  wire logic [15:0] bus_sample_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [15:0] reg_rdata_out,
  output logic             conversion_done_flag_out
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SHUNT = 3'b001,
    ST_BUS   = 3'b010,
    ST_CALC  = 3'b011,
    ST_PUB   = 3'b100
  } phase_e;

  typedef struct packed {
    phase_e                   st;
    logic [TIMER_W-1:0]       tmr;
    logic [10:0]              cnt;
    logic                     armed;
    logic [15:0]              cfg;
    logic [15:0]              cal;
    logic                     cal_ok;
    logic signed [15:0]       sh;
    logic [15:0]              bus;
    logic signed [ACC_W-1:0]  a_sh;
    logic signed [ACC_W-1:0]  a_cur;
    logic [ACC_W-1:0]         a_bus;
    logic [ACC_W-1:0]         a_pow;
    logic signed [15:0]       o_sh;
    logic signed [15:0]       o_cur;
    logic [15:0]              o_bus;
    logic [15:0]              o_pow;
    logic                     pub;
  } core_s;

  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] cal;
    logic [15:0] sh;
    logic [15:0] bus;
    logic [15:0] pow;
    logic [15:0] cur;
    logic [15:0] rdata;
    logic        done;
    logic        cfg_w;
    logic        cal_w;
  } link_s;

  core_s              c_r, c_nxt;
  link_s              l_r, l_nxt;
  logic               cfg_evt;
  logic               cal_evt;
  logic               pub_evt;
  logic               sh_en;
  logic               bus_en;
  logic [3:0]         shift;
  logic [10:0]        avg_n;
  logic [10:0]        cnt_inc;
  logic [TIMER_W-1:0] sh_cyc;
  logic [TIMER_W-1:0] bus_cyc;

  scale_if sc ();

  power_scaler u_scaler (
    .sc (sc.calc)
  );

  event_crossing u_cfg_x (
    .src_clk_in (link_clock_in),
    .dst_clk_in (clock_in),
    .reset_in   (reset_in),
    .pulse_in   (l_r.cfg_w),
    .pulse_out  (cfg_evt)
  );

  event_crossing u_cal_x (
    .src_clk_in (link_clock_in),
    .dst_clk_in (clock_in),
    .reset_in   (reset_in),
    .pulse_in   (l_r.cal_w),
    .pulse_out  (cal_evt)
  );

  event_crossing u_pub_x (
    .src_clk_in (clock_in),
    .dst_clk_in (link_clock_in),
    .reset_in   (reset_in),
    .pulse_in   (c_r.pub),
    .pulse_out  (pub_evt)
  );

  assign sc.shunt    = c_r.sh;
  assign sc.bus      = c_r.bus;
  assign sc.calib    = c_r.cal;
  assign sc.calib_ok = c_r.cal_ok;

  // Per-channel period and one shared averaging count from independent fields
  assign sh_en   = c_r.cfg[MODE_LSB + MODE_SHUNT];
  assign bus_en  = c_r.cfg[MODE_LSB + MODE_BUS];
  assign shift   = avg_shift(c_r.cfg[AVG_LSB +: FIELD_W]);
  assign avg_n   = 11'h001 << shift;
  assign cnt_inc = c_r.cnt + 11'h001;
  assign sh_cyc  = TIMER_W'(ct_us(c_r.cfg[SHUNT_CT_LSB +: FIELD_W])
                   * CYCLES_PER_US);
  assign bus_cyc = TIMER_W'(ct_us(c_r.cfg[BUS_CT_LSB +: FIELD_W])
                   * CYCLES_PER_US);

  // Measurement sequencer
  always_comb begin
    c_nxt     = c_r;
    c_nxt.pub = 1'b0;
    case (c_r.st)
      ST_IDLE: begin
        if ((sh_en || bus_en) && (c_r.cfg[MODE_CONT] || c_r.armed)) begin
          c_nxt.cnt   = 11'h000;
          c_nxt.a_sh  = '0;
          c_nxt.a_cur = '0;
          c_nxt.a_bus = '0;
          c_nxt.a_pow = '0;
          c_nxt.st    = sh_en ? ST_SHUNT : ST_BUS;
          c_nxt.tmr   = (sh_en ? sh_cyc : bus_cyc) - 1'b1;
        end
      end
      ST_SHUNT: begin
        if (c_r.tmr == '0) begin
          c_nxt.sh = shunt_sample_in;
          if (bus_en) begin
            c_nxt.st  = ST_BUS;
            c_nxt.tmr = bus_cyc - 1'b1;
          end else begin
            c_nxt.st = ST_CALC;
          end
        end else begin
          c_nxt.tmr = c_r.tmr - 1'b1;
        end
      end
      ST_BUS: begin
        if (c_r.tmr == '0) begin
          c_nxt.bus = bus_sample_in;
          c_nxt.st  = ST_CALC;
        end else begin
          c_nxt.tmr = c_r.tmr - 1'b1;
        end
      end
      ST_CALC: begin
        c_nxt.a_sh  = c_r.a_sh + ACC_W'(c_r.sh);
        c_nxt.a_bus = c_r.a_bus + ACC_W'(c_r.bus);
        c_nxt.a_cur = c_r.a_cur + ACC_W'(sc.current);
        c_nxt.a_pow = c_r.a_pow + ACC_W'(sc.power);
        c_nxt.cnt   = cnt_inc;
        if (cnt_inc == avg_n) begin
          c_nxt.st = ST_PUB;
        end else begin
          c_nxt.st  = sh_en ? ST_SHUNT : ST_BUS;
          c_nxt.tmr = (sh_en ? sh_cyc : bus_cyc) - 1'b1;
        end
      end
      ST_PUB: begin
        c_nxt.o_sh  = 16'(c_r.a_sh >>> shift);
        c_nxt.o_cur = 16'(c_r.a_cur >>> shift);
        c_nxt.o_bus = 16'(c_r.a_bus >> shift);
        c_nxt.o_pow = 16'(c_r.a_pow >> shift);
        c_nxt.pub   = 1'b1;
        c_nxt.armed = 1'b0;
        c_nxt.st    = ST_IDLE;
      end
      default: c_nxt.st = ST_IDLE;
    endcase
    // New configuration restarts the cycle
    if (cfg_evt) begin
      c_nxt.cfg   = l_r.cfg;
      c_nxt.armed = 1'b1;
      c_nxt.st    = ST_IDLE;
    end
    if (cal_evt) begin
      c_nxt.cal    = l_r.cal;
      c_nxt.cal_ok = 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      c_r     <= '0;
      c_r.st  <= ST_IDLE;
      c_r.cfg <= CONFIG_RESET;
      c_r.cal <= CALIB_RESET;
    end else begin
      c_r <= c_nxt;
    end
  end

  // Register port on the link clock
  always_comb begin
    l_nxt       = l_r;
    l_nxt.cfg_w = 1'b0;
    l_nxt.cal_w = 1'b0;
    if (reg_write_in) begin
      if (reg_addr_in == OFS_CONFIG) begin
        l_nxt.cfg   = reg_wdata_in;
        l_nxt.cfg_w = 1'b1;
        if (reg_wdata_in[MODE_LSB +: FIELD_W] != 3'h0) begin
          l_nxt.done = 1'b0;
        end
      end else if (reg_addr_in == OFS_CALIB) begin
        l_nxt.cal   = reg_wdata_in;
        l_nxt.cal_w = 1'b1;
      end
    end
    if (reg_read_in) begin
      if (reg_addr_in == OFS_CONFIG) begin
        l_nxt.rdata = l_r.cfg;
      end else if (reg_addr_in == OFS_SHUNT) begin
        l_nxt.rdata = l_r.sh;
      end else if (reg_addr_in == OFS_BUS) begin
        l_nxt.rdata = l_r.bus;
      end else if (reg_addr_in == OFS_POWER) begin
        l_nxt.rdata = l_r.pow;
      end else if (reg_addr_in == OFS_CURRENT) begin
        l_nxt.rdata = l_r.cur;
      end else if (reg_addr_in == OFS_CALIB) begin
        l_nxt.rdata = l_r.cal;
      end else if (reg_addr_in == OFS_STATUS) begin
        l_nxt.rdata = 16'(l_r.done) << DONE_BIT;
        l_nxt.done  = 1'b0;
      end else begin
        l_nxt.rdata = 16'h0000;
      end
    end
    // Publish wins over a clear in the same cycle
    if (pub_evt) begin
      l_nxt.sh   = c_r.o_sh;
      l_nxt.bus  = c_r.o_bus;
      l_nxt.cur  = c_r.o_cur;
      l_nxt.pow  = c_r.o_pow;
      l_nxt.done = 1'b1;
    end
  end

  always_ff @(posedge link_clock_in or posedge reset_in) begin
    if (reset_in) begin
      l_r     <= '0;
      l_r.cfg <= CONFIG_RESET;
      l_r.cal <= CALIB_RESET;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign reg_rdata_out            = l_r.rdata;
  assign conversion_done_flag_out = l_r.done;

  a_shunt_period: assert property (
    @(posedge clock_in) disable iff (reset_in)
    (c_r.st != ST_SHUNT ##1 c_r.st == ST_SHUNT) |-> c_r.tmr == sh_cyc - 1'b1)
    else $error("shunt period not loaded from its field");
  a_bus_period: assert property (
    @(posedge clock_in) disable iff (reset_in)
    (c_r.st != ST_BUS ##1 c_r.st == ST_BUS) |-> c_r.tmr == bus_cyc - 1'b1)
    else $error("bus period not loaded from its field");
  a_cfg_take: assert property (
    @(posedge clock_in) disable iff (reset_in)
    cfg_evt |=> c_r.cfg == $past(l_r.cfg) && c_r.st == ST_IDLE)
    else $error("configuration not taken whole");
  a_cal_take: assert property (
    @(posedge clock_in) disable iff (reset_in)
    cal_evt |=> c_r.cal_ok && c_r.cal == $past(l_r.cal))
    else $error("calibration not applied");
  a_zero_uncal: assert property (
    @(posedge clock_in) disable iff (reset_in)
    !c_r.cal_ok |-> sc.current == 16'h0000 && c_r.a_pow == '0)
    else $error("results not zero before calibration");
  a_current_scale: assert property (
    @(posedge clock_in) disable iff (reset_in)
    (c_r.cal_ok && c_r.sh == 16'h1F40 && c_r.cal == 16'h0A00)
    |-> sc.current == 16'h2710)
    else $error("current scaling wrong");
  a_power_scale: assert property (
    @(posedge clock_in) disable iff (reset_in)
    (c_r.cal_ok && c_r.sh == 16'h1F40 && c_r.cal == 16'h0A00
     && c_r.bus == 16'h2570) |-> sc.power == 16'h12B8)
    else $error("power scaling wrong");
  a_last_sample: assert property (
    @(posedge clock_in) disable iff (reset_in)
    (c_r.st == ST_CALC && cnt_inc == avg_n && !cfg_evt)
    |=> c_r.st == ST_PUB ##1 c_r.pub)
    else $error("publish missing after last sample");
  a_publish_cnt: assert property (
    @(posedge clock_in) disable iff (reset_in)
    c_r.pub |-> $past(c_r.cnt) == $past(avg_n))
    else $error("publish before full averaging count");
  a_done_flag: assert property (
    @(posedge link_clock_in) disable iff (reset_in)
    pub_evt |=> l_r.done && l_r.cur == $past(c_r.o_cur))
    else $error("done flag not set with results");
endmodule

// >>> rtl/meas_pkg.sv
// Shared constants and helpers of the measurement engine
package meas_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US     = 1000;
  localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
  localparam int TIMER_W       = 20;
  localparam int ACC_W         = 27;
  localparam int FIELD_W       = 3;

  localparam logic [7:0] OFS_CONFIG  = 8'h00;
  localparam logic [7:0] OFS_SHUNT   = 8'h01;
  localparam logic [7:0] OFS_BUS     = 8'h02;
  localparam logic [7:0] OFS_POWER   = 8'h03;
  localparam logic [7:0] OFS_CURRENT = 8'h04;
  localparam logic [7:0] OFS_CALIB   = 8'h05;
  localparam logic [7:0] OFS_STATUS  = 8'h06;

  localparam logic [15:0] CONFIG_RESET = 16'h4127;
  localparam logic [15:0] CALIB_RESET  = 16'h0000;

  localparam int AVG_LSB      = 9;
  localparam int BUS_CT_LSB   = 6;
  localparam int SHUNT_CT_LSB = 3;
  localparam int MODE_LSB     = 0;
  localparam int MODE_SHUNT   = 0;
  localparam int MODE_BUS     = 1;
  localparam int MODE_CONT    = 2;
  localparam int DONE_BIT     = 3;

  localparam int          CUR_DIV_SHIFT = 11;
  localparam logic [31:0] POWER_DIV     = 32'h0000_4E20;

  typedef logic [FIELD_W-1:0] field_t;

  // Conversion period in microseconds per setting
  function automatic int ct_us(input field_t sel);
    case (sel)
      3'h0: ct_us = 140;
      3'h1: ct_us = 204;
      3'h2: ct_us = 332;
      3'h3: ct_us = 588;
      3'h4: ct_us = 1100;
      3'h5: ct_us = 2116;
      3'h6: ct_us = 4156;
      default: ct_us = 8244;
    endcase
  endfunction

  // Log2 of the averaging count per setting
  function automatic logic [3:0] avg_shift(input field_t sel);
    case (sel)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'hA;
    endcase
  endfunction
endpackage

// >>> rtl/scale_if.sv
// Carrier between the sequencer and the scaling arithmetic
`timescale 1ns/1ps
interface scale_if;
  logic signed [15:0] shunt;
  logic        [15:0] bus;
  logic        [15:0] calib;
  logic               calib_ok;
  logic signed [15:0] current;
  logic        [15:0] power;
  modport calc (input shunt, bus, calib, calib_ok, output current, power);
  modport user (output shunt, bus, calib, calib_ok, input current, power);
endinterface

// >>> rtl/event_crossing.sv
// Toggle based event crossing between two clock domains
`timescale 1ns/1ps
module event_crossing (
  input  wire logic src_clk_in,
  input  wire logic dst_clk_in,
  input  wire logic reset_in,
  input  wire logic pulse_in,
  output logic      pulse_out
);
  typedef struct packed {
    logic tog;
  } src_s;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pulse;
  } dst_s;

  src_s s_r, s_nxt;
  dst_s d_r, d_nxt;

  always_comb begin
    s_nxt = s_r;
    if (pulse_in) begin
      s_nxt.tog = ~s_r.tog;
    end
  end

  always_ff @(posedge src_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    d_nxt       = d_r;
    d_nxt.s1    = s_r.tog;
    d_nxt.s2    = d_r.s1;
    d_nxt.s3    = d_r.s2;
    d_nxt.pulse = d_r.s2 ^ d_r.s3;
  end

  always_ff @(posedge dst_clk_in or posedge reset_in) begin
    if (reset_in) begin
      d_r <= '0;
    end else begin
      d_r <= d_nxt;
    end
  end

  assign pulse_out = d_r.pulse;
endmodule

// >>> rtl/power_scaler.sv
// Current and power scaling from one shunt and bus sample
`timescale 1ns/1ps
module power_scaler
  import meas_pkg::*;
(
  scale_if.calc sc
);
  logic signed [32:0] cur_prod;
  logic signed [32:0] cur_shift;
  logic        [15:0] cur_mag;
  logic        [31:0] pow_prod;
  logic        [31:0] pow_quot;

  always_comb begin
    cur_prod  = sc.shunt * $signed({1'b0, sc.calib});
    cur_shift = cur_prod >>> CUR_DIV_SHIFT;
    cur_mag   = cur_shift[15] ? 16'(-cur_shift) : cur_shift[15:0];
    pow_prod  = 32'(cur_mag) * 32'(sc.bus);
    pow_quot  = pow_prod / POWER_DIV;
    if (sc.calib_ok) begin
      sc.current = cur_shift[15:0];
      sc.power   = pow_quot[15:0];
    end else begin
      sc.current = 16'h0000;
      sc.power   = 16'h0000;
    end
  end
endmodule

// >>> dv/adc_model.sv
// Converter model that presents shunt and bus results to the core
`timescale 1ns/1ps
module adc_model (
  input  wire logic        clock_in,
  input  wire logic [15:0] shunt_level_in,
  input  wire logic [15:0] bus_level_in,
  output logic      [15:0] shunt_sample_out,
  output logic      [15:0] bus_sample_out
);
  initial begin
    shunt_sample_out = 16'h0000;
    bus_sample_out   = 16'h0000;
  end
  // Results change only off the sampling edge
  always @(negedge clock_in) begin
    shunt_sample_out <= shunt_level_in;
    bus_sample_out   <= bus_level_in;
  end
endmodule

// >>> dv/shunt_power_measurement_engine_tb.sv
// Register level bench of the measurement engine
`timescale 1ns/1ps
module shunt_power_measurement_engine_tb;
  import meas_pkg::*;
  logic        clk;
  logic        lclk;
  logic        rst;
  logic [15:0] shunt_lvl;
  logic [15:0] bus_lvl;
  logic [15:0] shunt_s;
  logic [15:0] bus_s;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        done;
  logic [15:0] v;
  logic [15:0] cfg_tab [2];
  int          exp_cyc [2];
  int          cal;
  int          mismatches;
  int          n_checks;
  int          cycles;
  realtime     t0;
  realtime     t1;

  shunt_power_measurement_engine #(.CYCLES_PER_US(1)) i_dut (
    .clock_in                 (clk),
    .reset_in                 (rst),
    .link_clock_in            (lclk),
    .shunt_sample_in          (shunt_s),
    .bus_sample_in            (bus_s),
    .reg_addr_in              (addr),
    .reg_wdata_in             (wdata),
    .reg_write_in             (wr),
    .reg_read_in              (rd),
    .reg_rdata_out            (rdata),
    .conversion_done_flag_out (done)
  );

  adc_model i_adc (
    .clock_in         (clk),
    .shunt_level_in   (shunt_lvl),
    .bus_level_in     (bus_lvl),
    .shunt_sample_out (shunt_s),
    .bus_sample_out   (bus_s)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;
  initial lclk = 1'b0;
  always begin
    #3.1;
    forever #7.5 lclk = ~lclk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_time(input realtime got, input realtime exp);
    n_checks++;
    if (got < exp - 40.0 || got > exp + 40.0) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, int'(got), int'(exp));
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge lclk);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge lclk);
    wr = 1'b0;
    repeat (10) @(negedge lclk);
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge lclk);
    addr = a;
    rd   = 1'b1;
    @(negedge lclk);
    rd = 1'b0;
    d  = rdata;
  endtask

  task automatic wait_done(output realtime t);
    int n;
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(negedge lclk);
      n++;
    end
    t = $realtime;
    check16({15'h0, done}, 16'h0001);
  endtask

  task automatic clear_done();
    reg_rd(OFS_STATUS, v);
    check16(v & 16'h0008, 16'h0008);
  endtask

  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    shunt_lvl = 16'h1F40;
    bus_lvl = 16'h2570;
    mismatches = 0;
    n_checks = 0;
    cycles = 0;
    cfg_tab[0] = 16'h020F;
    exp_cyc[0] = 4 * (204 + 140 + 1) + 2;
    cfg_tab[1] = 16'h003F;
    exp_cyc[1] = 8244 + 140 + 1 + 2;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    reg_rd(OFS_CONFIG, v);
    check16(v, CONFIG_RESET);
    reg_rd(OFS_CALIB, v);
    check16(v, CALIB_RESET);
    reg_rd(8'h07, v);
    check16(v, 16'h0000);
    reg_wr(OFS_CONFIG, 16'h0007);
    wait_done(t0);
    clear_done();
    reg_rd(OFS_CURRENT, v);
    check16(v, 16'h0000);
    reg_rd(OFS_POWER, v);
    check16(v, 16'h0000);
    reg_rd(OFS_SHUNT, v);
    check16(v, 16'h1F40);
    reg_rd(OFS_BUS, v);
    check16(v, 16'h2570);
    // Step of 1 mA rounded up from 15 A over 2**15, sense of 2 mohm
    cal = $rtoi(0.00512 / (0.001 * 0.002) + 0.5);
    reg_wr(OFS_CALIB, cal[15:0]);
    repeat (2) begin
      wait_done(t0);
      clear_done();
    end
    reg_rd(OFS_CURRENT, v);
    check16(v, 16'h2710);
    reg_rd(OFS_POWER, v);
    check16(v, 16'h12B8);
    reg_wr(OFS_POWER, 16'h1234);
    reg_rd(OFS_POWER, v);
    check16(v, 16'h12B8);
    shunt_lvl = 16'hE0C0;
    repeat (2) begin
      wait_done(t0);
      clear_done();
    end
    reg_rd(OFS_CURRENT, v);
    check16(v, 16'hD8F0);
    reg_rd(OFS_POWER, v);
    check16(v, 16'h12B8);
    for (int i = 0; i < 2; i++) begin
      reg_wr(OFS_CONFIG, cfg_tab[i]);
      reg_rd(OFS_CONFIG, v);
      check16(v, cfg_tab[i]);
      wait_done(t0);
      clear_done();
      wait_done(t1);
      clear_done();
      check_time(t1 - t0, exp_cyc[i] * 10.0);
      reg_rd(OFS_CURRENT, v);
      check16(v, 16'hD8F0);
      reg_rd(OFS_POWER, v);
      check16(v, 16'h12B8);
    end
    // Single-shot mode runs one cycle per configuration write
    reg_wr(OFS_CONFIG, 16'h0003);
    wait_done(t0);
    clear_done();
    repeat (400) @(negedge lclk);
    check16({15'h0, done}, 16'h0000);
    reg_rd(OFS_STATUS, v);
    check16(v & 16'h0008, 16'h0000);
    complete_run();
  end
endmodule
